// File: hw/dat_params.svh
`ifndef DAT_PARAMS_SVH
`define DAT_PARAMS_SVH

// default (logical) geometry
`define DAT_SPT_DEFAULT    8'd63
`define DAT_HEADS_SMALL    5'd15
`define DAT_HEADS_LARGE    5'd16
`define DAT_CYL_SMALL      16'd8959
`define DAT_CYL_LARGE      16'd16383

// example zone layout of one physical track
`define DAT_ZONE_DATA_SEC  10'd574
`define DAT_ZONE_SPARE_SEC 10'd2
`define DAT_ZONE_TRACK_SEC 10'd576

// physical layout
`define DAT_PHYS_HEADS     5'd2
`define DAT_ALT_CYL        16'h3FFF

// defect handling
`define DAT_RETRY_LIMIT    4'h8
`define DAT_DEF_SLOTS      8

// identification words
`define DAT_ID_WORD_CYL    8'd54
`define DAT_ID_WORD_HEADS  8'd55
`define DAT_ID_WORD_SPT    8'd56

`endif

// File: hw/dat_pkg.sv
package dat_pkg;

  typedef struct packed {
    logic        lba_mode;
    logic [15:0] cyl;
    logic [3:0]  head;
    logic [7:0]  sector;
    logic [27:0] lba;
  } dat_req_t;

  typedef struct packed {
    logic [15:0] cyl;
    logic [4:0]  head;
    logic [9:0]  sector;
    logic        alt;
    logic [15:0] resume_cyl;
    logic [4:0]  resume_head;
  } dat_phys_t;

  typedef struct packed {
    logic        valid;
    logic        slip;
    logic [19:0] track;
    logic [9:0]  sector;
    logic [4:0]  alt_head;
    logic [9:0]  alt_sector;
  } dat_defect_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_DIV_TRK,
    ST_DIV_HEAD,
    ST_SLIP,
    ST_DONE,
    ST_DIV_GEO,
    ST_REWRITE,
    ST_REREAD,
    ST_ASSIGN
  } dat_state_t;

endpackage

// File: hw/dat_divider.sv
`timescale 1ns/1ns
module dat_divider (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // operands
  input  wire logic        start,
  input  wire logic [31:0] dividend,
  input  wire logic [15:0] divisor,
  // result
  output logic             done,
  output logic [31:0]      quotient,
  output logic [15:0]      remainder
);

  logic [31:0] quo_r;
  logic [32:0] rem_r;
  logic [15:0] dvs_r;
  logic [5:0]  cnt_r;
  logic        busy_r;
  logic        done_r;
  logic [32:0] trial;

  assign trial = {rem_r[31:0], quo_r[31]} - {17'h00000, dvs_r};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      quo_r  <= 32'h00000000;
      rem_r  <= 33'h000000000;
      dvs_r  <= 16'h0000;
      cnt_r  <= 6'h00;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      if (start)
      begin
        quo_r  <= dividend;
        rem_r  <= 33'h000000000;
        dvs_r  <= divisor;
        cnt_r  <= 6'h20;
        busy_r <= 1'b1;
      end
      else if (busy_r)
      begin
        // restoring step, one quotient bit per clock
        if (!trial[32])
        begin
          rem_r <= trial;
          quo_r <= {quo_r[30:0], 1'b1};
        end
        else
        begin
          rem_r <= {rem_r[31:0], quo_r[31]};
          quo_r <= {quo_r[30:0], 1'b0};
        end
        cnt_r <= cnt_r - 6'h01;
        if (cnt_r == 6'h01)
        begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end

  assign done      = done_r;
  assign quotient  = quo_r;
  assign remainder = rem_r[15:0];

endmodule // dat_divider

// File: hw/dat_top.sv
// How it works
// - every medium access translated logical to physical
// - current mode uses host-set heads and sectors
// - defaults: 63 sectors, 15/8959 or 16/16383
// - identify words 54-56 report current geometry
// - chs numbering starts c0 h0 s1, head advances
// - block 0 is cylinder 0 head 0 sector 1
// - after last data sector, next track begins
// - sectors 1-574 carry data, two spares unnumbered
// - two spare sectors per track for slipping
// - one spare cylinder for overflow and reassignment
// - slip skips defect, shifts following addresses along
// - alternate cylinder for third defect, auto reassignment; code picks slip or alternate by the entry's slip bit, not by defect count
// - alternate cylinder outer side, next unassigned sector
// - alternate access, then back to original track
// - reassign when read retries exceed threshold
// - rewrite and reread first, skip if clean
// - at most one reassignment per read command
// - reassign on unrecovered write error
`timescale 1ns/1ns
`include "dat_params.svh"
module dat_top (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // capacity strap
  input  wire logic               big_variant,
  // translation request
  input  wire logic               req_valid,
  output logic                    req_ready,
  input  wire dat_pkg::dat_req_t  req,
  // translation answer
  output logic                    resp_valid,
  input  wire logic               resp_ready,
  output dat_pkg::dat_phys_t      resp,
  // geometry set command
  input  wire logic               geo_valid,
  output logic                    geo_ready,
  input  wire logic [4:0]         geo_heads,
  input  wire logic [7:0]         geo_spt,
  // identify word read
  input  wire logic [7:0]         id_addr,
  output logic [15:0]             id_data,
  // command boundary
  input  wire logic               cmd_start,
  // factory defect load
  input  wire logic               load_valid,
  output logic                    load_ready,
  input  wire dat_pkg::dat_defect_t load_entry,
  // error reports from the read/write channel
  input  wire logic               rd_err_valid,
  input  wire logic               wr_err_valid,
  output logic                    err_ready,
  input  wire logic [3:0]         rd_retries,
  input  wire logic [15:0]        err_cyl,
  input  wire logic [4:0]         err_head,
  input  wire logic [9:0]         err_sector,
  // rewrite / reread requests to the channel
  output logic                    fix_req,
  output logic                    fix_reread,
  input  wire logic               fix_done,
  input  wire logic               fix_err,
  // status
  output logic                    table_full,
  output logic                    alt_full
);
  import dat_pkg::*;

  dat_state_t  state_r;
  dat_defect_t tbl_r [`DAT_DEF_SLOTS];
  logic [3:0]  tbl_cnt_r;
  logic        variant_r;
  logic        strap_done_r;
  logic        geo_set_r;
  logic [4:0]  heads_r;
  logic [7:0]  spt_r;
  logic [15:0] id_cyl_r;
  logic [15:0] id_data_r;
  logic [31:0] lin_r;
  logic [19:0] track_r;
  logic [9:0]  psec_r;
  logic [15:0] pcyl_r;
  logic [4:0]  phead_r;
  dat_phys_t   resp_r;
  logic        reassigned_r;
  logic        from_rd_r;
  logic [19:0] fail_track_r;
  logic [9:0]  fail_sec_r;
  logic [4:0]  alt_head_r;
  logic [9:0]  alt_sec_r;

  logic [4:0]  def_heads;
  logic [15:0] def_cyl;
  logic [4:0]  cur_heads;
  logic [7:0]  cur_spt;
  logic [31:0] chs_lin;
  logic [31:0] def_cap;
  logic        div_start;
  logic [31:0] div_dividend;
  logic [15:0] div_divisor;
  logic        div_done;
  logic [31:0] div_quo;
  logic [15:0] div_rem;
  logic [9:0]  slip_sec;
  logic        alt_hit;
  logic [4:0]  alt_hit_head;
  logic [9:0]  alt_hit_sec;
  logic        req_acc;
  logic        geo_acc;
  logic        rd_acc;
  logic        wr_acc;
  logic        any_def;

  // strap caught once after reset release
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      variant_r    <= 1'b0;
      strap_done_r <= 1'b0;
    end
    else if (!strap_done_r)
    begin
      variant_r    <= big_variant;
      strap_done_r <= 1'b1;
    end
  end

  assign def_heads = variant_r ? `DAT_HEADS_LARGE : `DAT_HEADS_SMALL;
  assign def_cyl   = variant_r ? `DAT_CYL_LARGE : `DAT_CYL_SMALL;
  assign cur_heads = geo_set_r ? heads_r : def_heads;
  assign cur_spt   = geo_set_r ? spt_r : `DAT_SPT_DEFAULT;
  assign def_cap   = 32'(def_cyl) * 32'(def_heads) * 32'(`DAT_SPT_DEFAULT);

  // chs to linear, numbering from sector 1 of head 0
  assign chs_lin = 32'((32'(req.cyl) * 32'(cur_heads) + 32'(req.head)) * 32'(cur_spt)
                   + 32'(req.sector) - 32'd1);

  assign req_ready  = (state_r == ST_IDLE);
  assign geo_ready  = (state_r == ST_IDLE) && !req_valid;
  assign err_ready  = (state_r == ST_IDLE) && !req_valid && !geo_valid;
  assign load_ready = (state_r == ST_IDLE) && !req_valid && !geo_valid && !rd_err_valid && !wr_err_valid;
  assign req_acc    = req_valid && req_ready;
  assign geo_acc    = geo_valid && geo_ready;
  assign rd_acc     = rd_err_valid && err_ready;
  assign wr_acc     = wr_err_valid && err_ready && !rd_err_valid;

  // one shared divider: track split, head split, identify cylinders
  always_comb
  begin
    div_start    = 1'b0;
    div_dividend = 32'h00000000;
    div_divisor  = 16'h0001;
    if (req_acc)
    begin
      div_start    = 1'b1;
      div_dividend = req.lba_mode ? {4'h0, req.lba} : chs_lin;
      div_divisor  = {6'h00, `DAT_ZONE_DATA_SEC};
    end
    else if (geo_acc)
    begin
      div_start    = 1'b1;
      div_dividend = def_cap;
      div_divisor  = 16'(geo_heads) * 16'(geo_spt);
    end
    else if (state_r == ST_DIV_TRK && div_done)
    begin
      div_start    = 1'b1;
      div_dividend = 32'(div_quo[19:0]);
      div_divisor  = {11'h000, `DAT_PHYS_HEADS};
    end
  end

  dat_divider u_div (
    .clk       (clk),
    .rst_n     (rst_n),
    .start     (div_start),
    .dividend  (div_dividend),
    .divisor   (div_divisor),
    .done      (div_done),
    .quotient  (div_quo),
    .remainder (div_rem)
  );

  // slip over defects on the track, then look for an alternate
  always_comb
  begin
    slip_sec     = psec_r;
    alt_hit      = 1'b0;
    alt_hit_head = 5'h00;
    alt_hit_sec  = 10'h000;
    any_def      = 1'b0;
    for (int i = 0; i < `DAT_DEF_SLOTS; i++)
    begin
      any_def = any_def | tbl_r[i].valid;
      if (tbl_r[i].valid && tbl_r[i].slip && tbl_r[i].track == track_r && tbl_r[i].sector <= slip_sec)
      begin
        slip_sec = slip_sec + 10'h001;
      end
    end
    for (int i = 0; i < `DAT_DEF_SLOTS; i++)
    begin
      if (tbl_r[i].valid && !tbl_r[i].slip && tbl_r[i].track == track_r && tbl_r[i].sector == slip_sec)
      begin
        alt_hit      = 1'b1;
        alt_hit_head = tbl_r[i].alt_head;
        alt_hit_sec  = tbl_r[i].alt_sector;
      end
    end
  end

  // main sequencer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          if (req_acc)
            state_r <= ST_DIV_TRK;
          else if (geo_acc)
            state_r <= ST_DIV_GEO;
          else if (rd_acc && rd_retries > `DAT_RETRY_LIMIT && !reassigned_r)
            state_r <= ST_REWRITE;
          else if (wr_acc)
            state_r <= ST_ASSIGN;
        end
        ST_DIV_TRK:  if (div_done) state_r <= ST_DIV_HEAD;
        ST_DIV_HEAD: if (div_done) state_r <= ST_SLIP;
        ST_SLIP:     state_r <= ST_DONE;
        ST_DONE:     if (resp_ready) state_r <= ST_IDLE;
        ST_DIV_GEO:  if (div_done) state_r <= ST_IDLE;
        ST_REWRITE:  if (fix_done) state_r <= ST_REREAD;
        ST_REREAD:   if (fix_done) state_r <= fix_err ? ST_ASSIGN : ST_IDLE;
        ST_ASSIGN:   state_r <= ST_IDLE;
        default:     state_r <= ST_IDLE;
      endcase
    end
  end

  // translation datapath
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lin_r   <= 32'h00000000;
      track_r <= 20'h00000;
      psec_r  <= 10'h001;
      pcyl_r  <= 16'h0000;
      phead_r <= 5'h00;
      resp_r  <= '0;
    end
    else
    begin
      if (req_acc)
        lin_r <= req.lba_mode ? {4'h0, req.lba} : chs_lin;
      if (state_r == ST_DIV_TRK && div_done)
      begin
        track_r <= div_quo[19:0];
        psec_r  <= div_rem[9:0] + 10'h001;
      end
      if (state_r == ST_DIV_HEAD && div_done)
      begin
        pcyl_r  <= div_quo[15:0];
        phead_r <= div_rem[4:0];
      end
      if (state_r == ST_SLIP)
      begin
        resp_r.resume_cyl  <= pcyl_r;
        resp_r.resume_head <= phead_r;
        resp_r.alt         <= alt_hit;
        if (alt_hit)
        begin
          resp_r.cyl    <= `DAT_ALT_CYL;
          resp_r.head   <= alt_hit_head;
          resp_r.sector <= alt_hit_sec;
        end
        else
        begin
          resp_r.cyl    <= pcyl_r;
          resp_r.head   <= phead_r;
          resp_r.sector <= slip_sec;
        end
      end
    end
  end

  assign resp_valid = (state_r == ST_DONE);
  assign resp       = resp_r;

  // host geometry, lost on reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      geo_set_r <= 1'b0;
      heads_r   <= 5'h00;
      spt_r     <= 8'h00;
      id_cyl_r  <= 16'h0000;
    end
    else
    begin
      if (geo_acc)
      begin
        geo_set_r <= 1'b1;
        heads_r   <= geo_heads;
        spt_r     <= geo_spt;
      end
      // cylinder count is only an estimate; a quotient above 16 bits saturates to 16'hFFFF
      if (state_r == ST_DIV_GEO && div_done)
        id_cyl_r <= (div_quo[31:16] != 16'h0000) ? 16'hFFFF : div_quo[15:0];
    end
  end

  // identify words
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      id_data_r <= 16'h0000;
    else
    begin
      unique case (id_addr)
        `DAT_ID_WORD_CYL:   id_data_r <= geo_set_r ? id_cyl_r : def_cyl;
        `DAT_ID_WORD_HEADS: id_data_r <= 16'(cur_heads);
        `DAT_ID_WORD_SPT:   id_data_r <= 16'(cur_spt);
        default:            id_data_r <= 16'h0000;
      endcase
    end
  end

  assign id_data = id_data_r;

  // reassignment bookkeeping
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reassigned_r <= 1'b0;
      from_rd_r    <= 1'b0;
      fail_track_r <= 20'h00000;
      fail_sec_r   <= 10'h000;
    end
    else
    begin
      if (state_r == ST_ASSIGN && from_rd_r)
        reassigned_r <= 1'b1;
      else if (cmd_start)
        reassigned_r <= 1'b0;
      if (rd_acc || wr_acc)
      begin
        from_rd_r    <= rd_acc;
        fail_track_r <= 20'(32'(err_cyl) * 32'(`DAT_PHYS_HEADS) + 32'(err_head));
        fail_sec_r   <= err_sector;
      end
    end
  end

  assign fix_req    = (state_r == ST_REWRITE) || (state_r == ST_REREAD);
  assign fix_reread = (state_r == ST_REREAD);

  // defect table and alternate cylinder allocation
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < `DAT_DEF_SLOTS; i++)
        tbl_r[i] <= '0;
      tbl_cnt_r  <= 4'h0;
      alt_head_r <= 5'h00;
      alt_sec_r  <= 10'h001;
    end
    else if (!table_full)
    begin
      if (load_valid && load_ready)
      begin
        tbl_r[tbl_cnt_r[2:0]]       <= load_entry;
        tbl_r[tbl_cnt_r[2:0]].valid <= 1'b1;
        if (!load_entry.slip)
        begin
          tbl_r[tbl_cnt_r[2:0]].alt_head   <= alt_head_r;
          tbl_r[tbl_cnt_r[2:0]].alt_sector <= alt_sec_r;
        end
        tbl_cnt_r <= tbl_cnt_r + 4'h1;
      end
      else if (state_r == ST_ASSIGN && !alt_full)
      begin
        tbl_r[tbl_cnt_r[2:0]] <= '{valid: 1'b1, slip: 1'b0, track: fail_track_r, sector: fail_sec_r,
                                   alt_head: alt_head_r, alt_sector: alt_sec_r};
        tbl_cnt_r <= tbl_cnt_r + 4'h1;
      end
      if (((load_valid && load_ready && !load_entry.slip) || state_r == ST_ASSIGN) && !alt_full)
      begin
        if (alt_sec_r == `DAT_ZONE_TRACK_SEC)
        begin
          alt_sec_r  <= 10'h001;
          alt_head_r <= alt_head_r + 5'h01;
        end
        else
          alt_sec_r <= alt_sec_r + 10'h001;
      end
    end
  end

  assign table_full = (tbl_cnt_r == 4'(`DAT_DEF_SLOTS));
  assign alt_full   = (alt_head_r == `DAT_PHYS_HEADS);

  lin_calc_a: assert property (@(posedge clk) disable iff (!rst_n)
    req_acc && !req.lba_mode |=> lin_r == 32'((32'($past(req.cyl)) * 32'($past(cur_heads))
      + 32'($past(req.head))) * 32'($past(cur_spt)) + 32'($past(req.sector)) - 32'd1))
    else $error("chs linear value wrong");

  default_geo_a: assert property (@(posedge clk) disable iff (!rst_n)
    !geo_set_r |-> cur_spt == 8'd63 && (cur_heads == 5'd15 || cur_heads == 5'd16))
    else $error("default geometry wrong");

  zone_sec_a: assert property (@(posedge clk) disable iff (!rst_n)
    resp_valid && !any_def |-> resp.sector >= 10'd1 && resp.sector <= 10'd574)
    else $error("sector outside data area");

  block_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    resp_valid && lin_r == 32'h00000000 && !any_def |-> resp.cyl == 16'h0000 && resp.head == 5'h00
      && resp.sector == 10'h001)
    else $error("block zero misplaced");

  alt_route_a: assert property (@(posedge clk) disable iff (!rst_n)
    resp_valid && resp.alt |-> resp.cyl == `DAT_ALT_CYL && resp.resume_cyl == pcyl_r
      && resp.resume_head == phead_r)
    else $error("alternate route wrong");

  retry_thresh_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_acc && rd_retries <= `DAT_RETRY_LIMIT |=> state_r == ST_IDLE)
    else $error("reassign below threshold");

  reread_skip_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == ST_REREAD && fix_done && !fix_err |=> state_r == ST_IDLE && $stable(tbl_cnt_r))
    else $error("clean reread reassigned");

  one_per_cmd_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == ST_ASSIGN && from_rd_r |-> !reassigned_r)
    else $error("second reassignment in command");

  wr_assign_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_acc |=> state_r == ST_ASSIGN ##1 state_r == ST_IDLE)
    else $error("write error not reassigned");

  // word register still held in reset at the release edge
  id_heads_a: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n && id_addr == `DAT_ID_WORD_HEADS |=> id_data == 16'($past(cur_heads)))
    else $error("identify heads word wrong");

endmodule // dat_top

// File: testbench/dat_chan_model.sv
`timescale 1ns/1ns
module dat_chan_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // rewrite and reread requests
  input  wire logic fix_req,
  input  wire logic fix_reread,
  output logic      fix_done,
  output logic      fix_err,
  // scenario control
  input  wire logic bad_reread
);
  import dat_pkg::*;
  logic [1:0] wait_r;
  logic       fire;
  assign fire = fix_req && !fix_done && wait_r == 2'h2;
  // each request answered three cycles after it appears
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      wait_r   <= 2'h0;
      fix_done <= 1'b0;
    end
    else
    begin
      fix_done <= fire;
      wait_r   <= (!fix_req || fix_done || fire) ? 2'h0 : wait_r + 2'h1;
    end
  // error flag valid with done only, toggles otherwise
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      fix_err <= 1'b0;
    else
      fix_err <= fire ? (bad_reread && fix_reread) : !fix_err;
endmodule // dat_chan_model

// File: testbench/dat_top_tb.sv
`timescale 1ns/1ns
module dat_top_tb;
  import dat_pkg::*;
  logic        clk, rst_n, big_variant, req_valid, resp_ready, geo_valid, cmd_start;
  logic        load_valid, rd_err_valid, wr_err_valid, fix_done, fix_err, bad_reread;
  logic        req_ready, resp_valid, geo_ready, load_ready, err_ready, fix_req, fix_reread;
  logic        table_full, alt_full;
  dat_req_t    req;
  dat_phys_t   resp;
  dat_defect_t load_entry;
  logic [4:0]  geo_heads, err_head;
  logic [7:0]  geo_spt, id_addr;
  logic [15:0] id_data, err_cyl;
  logic [3:0]  rd_retries;
  logic [9:0]  err_sector;
  int          fail_count, num_checks, n_rw, n_rr;

  dat_top dut (.clk(clk), .rst_n(rst_n), .big_variant(big_variant), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .resp_valid(resp_valid), .resp_ready(resp_ready),
    .resp(resp), .geo_valid(geo_valid), .geo_ready(geo_ready), .geo_heads(geo_heads),
    .geo_spt(geo_spt), .id_addr(id_addr), .id_data(id_data), .cmd_start(cmd_start),
    .load_valid(load_valid), .load_ready(load_ready), .load_entry(load_entry),
    .rd_err_valid(rd_err_valid), .wr_err_valid(wr_err_valid), .err_ready(err_ready),
    .rd_retries(rd_retries), .err_cyl(err_cyl), .err_head(err_head), .err_sector(err_sector),
    .fix_req(fix_req), .fix_reread(fix_reread), .fix_done(fix_done), .fix_err(fix_err),
    .table_full(table_full), .alt_full(alt_full));

  dat_chan_model u_chan (.clk(clk), .rst_n(rst_n), .fix_req(fix_req), .fix_reread(fix_reread),
    .fix_done(fix_done), .fix_err(fix_err), .bad_reread(bad_reread));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = !clk;
  end

  always @(posedge clk)
    if (fix_req && fix_done)
    begin
      if (fix_reread)
        n_rr++;
      else
        n_rw++;
    end

  task complete_run;
    $display("checks %0d failures %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk_p(string n, dat_phys_t e, dat_phys_t g);
    num_checks++;
    if ({g.cyl, g.head, g.sector, g.alt} !== {e.cyl, e.head, e.sector, e.alt} ||
        (e.alt && {g.resume_cyl, g.resume_head} !== {e.resume_cyl, e.resume_head}))
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_w(string n, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic sig(int k);
    case (k)
      0: return req_ready;
      1: return resp_valid;
      2: return geo_ready;
      3: return load_ready && !table_full;
      default: return err_ready;
    endcase
  endfunction

  // waits at falling edges so the next rising edge takes the request
  task automatic till(int k);
    int i;
    i = 0;
    @(negedge clk);
    while (sig(k) !== 1'b1 && i < 200)
    begin
      i++;
      @(negedge clk);
    end
    if (i == 200)
      chk_w("handshake", 16'h1, 16'h0);
  endtask

  function automatic dat_phys_t ph(int c, int h, int s, bit a, int rc, int rh);
    return '{16'(c), 5'(h), 10'(s), a, 16'(rc), 5'(rh)};
  endfunction

  function automatic dat_phys_t lb(int n);
    return ph(n / 1148, (n / 574) % 2, n % 574 + 1, 1'b0, 0, 0);
  endfunction

  task automatic rst(bit bv);
    @(posedge clk) rst_n <= 1'b0;
    big_variant <= bv;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  task automatic xl(bit m, int c, int h, int s, int l, dat_phys_t e);
    @(posedge clk) req_valid <= 1'b1;
    req <= '{m, 16'(c), 4'(h), 8'(s), 28'(l)};
    till(0);
    @(posedge clk) req_valid <= 1'b0;
    till(1);
    chk_p("resp", e, resp);
    @(posedge clk) resp_ready <= 1'b1;
    @(posedge clk) resp_ready <= 1'b0;
  endtask

  task automatic idw(logic [7:0] a, logic [15:0] e);
    @(posedge clk) id_addr <= a;
    @(posedge clk);
    @(negedge clk);
    chk_w("id_data", e, id_data);
  endtask

  task automatic ld(bit slip, int t, int s);
    @(posedge clk) load_valid <= 1'b1;
    load_entry <= '{1'b1, slip, 20'(t), 10'(s), 5'h00, 10'h000};
    till(3);
    @(posedge clk) load_valid <= 1'b0;
    @(posedge clk);
  endtask

  task automatic er(bit rd, bit bad, logic [3:0] r, int c, int h, int s);
    @(posedge clk) rd_err_valid <= rd;
    wr_err_valid <= !rd;
    bad_reread <= bad;
    rd_retries <= r;
    err_cyl <= 16'(c);
    err_head <= 5'(h);
    err_sector <= 10'(s);
    till(4);
    @(posedge clk) rd_err_valid <= 1'b0;
    wr_err_valid <= 1'b0;
    till(0);
  endtask

  task automatic cmd;
    @(posedge clk) cmd_start <= 1'b1;
    @(posedge clk) cmd_start <= 1'b0;
  endtask

  task automatic t_id;
    rst(1'b1);
    idw(8'h36, 16'h3FFF);
    idw(8'h37, 16'h0010);
    rst(1'b0);
    idw(8'h36, 16'h22FF);
    idw(8'h37, 16'h000F);
    idw(8'h38, 16'h003F);
    idw(8'h39, 16'h0000);
  endtask

  task automatic t_lba;
    xl(1'b1, 0, 0, 0, 0, lb(0));
    xl(1'b1, 0, 0, 0, 573, lb(573));
    xl(1'b1, 0, 0, 0, 574, lb(574));
    xl(1'b1, 0, 0, 0, 1147, lb(1147));
    xl(1'b1, 0, 0, 0, 1148, lb(1148));
  endtask

  task automatic t_chs;
    xl(1'b0, 0, 0, 1, 0, lb(0));
    xl(1'b0, 0, 0, 63, 0, lb(62));
    xl(1'b0, 0, 1, 1, 0, lb(63));
    xl(1'b0, 1, 0, 1, 0, lb(945));
    xl(1'b0, 2, 14, 63, 0, lb(2834));
  endtask

  task automatic t_defect;
    ld(1'b1, 0, 5);
    xl(1'b1, 0, 0, 0, 3, ph(0, 0, 4, 1'b0, 0, 0));
    xl(1'b1, 0, 0, 0, 4, ph(0, 0, 6, 1'b0, 0, 0));
    xl(1'b1, 0, 0, 0, 573, ph(0, 0, 575, 1'b0, 0, 0));
    xl(1'b1, 0, 0, 0, 574, lb(574));
    ld(1'b0, 0, 10);
    xl(1'b1, 0, 0, 0, 8, ph(16'h3FFF, 0, 1, 1'b1, 0, 0));
    xl(1'b1, 0, 0, 0, 9, ph(0, 0, 11, 1'b0, 0, 0));
    er(1'b0, 1'b0, 4'h0, 0, 1, 20);
    xl(1'b1, 0, 0, 0, 593, ph(16'h3FFF, 0, 2, 1'b1, 0, 1));
  endtask

  task automatic t_read;
    cmd;
    er(1'b1, 1'b1, 4'h8, 1, 0, 30);
    chk_w("rewrites", 16'h0, 16'(n_rw));
    xl(1'b1, 0, 0, 0, 1177, lb(1177));
    er(1'b1, 1'b0, 4'h9, 1, 0, 31);
    chk_w("rewrites", 16'h1, 16'(n_rw));
    chk_w("rereads", 16'h1, 16'(n_rr));
    xl(1'b1, 0, 0, 0, 1178, lb(1178));
    er(1'b1, 1'b1, 4'h9, 1, 0, 32);
    chk_w("rereads", 16'h2, 16'(n_rr));
    xl(1'b1, 0, 0, 0, 1179, ph(16'h3FFF, 0, 3, 1'b1, 1, 0));
    er(1'b1, 1'b1, 4'h9, 1, 0, 33);
    chk_w("rewrites", 16'h2, 16'(n_rw));
    xl(1'b1, 0, 0, 0, 1180, lb(1180));
    cmd;
    er(1'b1, 1'b1, 4'h9, 1, 0, 33);
    xl(1'b1, 0, 0, 0, 1180, ph(16'h3FFF, 0, 4, 1'b1, 1, 0));
    ld(1'b1, 5, 1);
    ld(1'b1, 5, 2);
    ld(1'b0, 5, 3);
    @(negedge clk);
    chk_w("table_full", 16'h1, 16'(table_full));
    chk_w("alt_full", 16'h0, 16'(alt_full));
  endtask

  task automatic t_geo;
    @(posedge clk) geo_valid <= 1'b1;
    geo_heads <= 5'h10;
    geo_spt <= 8'h3F;
    till(2);
    @(posedge clk) geo_valid <= 1'b0;
    till(0);
    idw(8'h37, 16'h0010);
    idw(8'h38, 16'h003F);
    idw(8'h36, 16'h20CF);
    xl(1'b0, 1, 0, 1, 0, lb(1008));
    rst(1'b0);
    idw(8'h37, 16'h000F);
  endtask

  initial
  begin
    {rst_n, big_variant, req_valid, resp_ready, geo_valid, cmd_start} = '0;
    {load_valid, rd_err_valid, wr_err_valid, bad_reread} = '0;
    {req, load_entry, geo_heads, geo_spt, id_addr} = '0;
    {rd_retries, err_cyl, err_head, err_sector} = '0;
    t_id;
    t_lba;
    t_chs;
    t_defect;
    t_read;
    t_geo;
    complete_run;
  end

  initial
  begin
    #1000000;
    chk_w("watchdog", 16'h1, 16'h0);
    complete_run;
  end
endmodule // dat_top_tb
